//--- bench/afr_regs_asserts.sv
// afr_regs_asserts.sv: port-level checks for the fault and ramp register slice.
// assumes: bound onto afr_regs; one clock, synchronous active high reset.
`default_nettype none
module afr_regs_asserts
(
   // clock and reset
   input wire logic       mclk,
   input wire logic       sys_rst,
   // control port
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   // mode and one detector
   input wire logic       ramp_manual_mode,
   input wire logic       clock_fault,
   // ramp settings and report
   input wire logic [7:0] ramp_divisor,
   input wire logic [3:0] tri_fall_step,
   input wire logic [3:0] tri_rise_step,
   input wire logic [1:0] ramp_amplitude_sel,
   input wire logic [4:0] tri_period_limit,
   input wire logic       ramp_tick,
   input wire logic       fault_report,
   input wire logic       fault_report_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // *******************
   // properties
   // *******************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   // a write to one offset that the next cycle leaves alone
   sequence s_wr(a);
      reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
   endsequence
   // a detector held for four cycles, then its status read
   sequence s_clk_seen;
      clock_fault [*4] ##1 (reg_rd && reg_addr == 8'h71);
   endsequence

   a_div_write:
      assert property (s_wr(8'h6D) |=> ramp_divisor == $past(reg_wdata, 2))
      else $error("divisor output not the written value");
   a_step_write:
      assert property (s_wr(8'h6E) |=> {tri_fall_step, tri_rise_step} == $past(reg_wdata, 2))
      else $error("step outputs not the written value");
   a_shape_write:
      assert property (s_wr(8'h6F) |=>
         {ramp_amplitude_sel, tri_period_limit} == $past(reg_wdata[6:0], 2))
      else $error("shape outputs not the written value");
   a_unmapped_zero:
      assert property (reg_rd && (reg_addr < 8'h6D || reg_addr > 8'h74) |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_chan_reserved:
      assert property (reg_rd && reg_addr == 8'h70 |=> reg_rdata[7:4] == 4'h0)
      else $error("channel fault reserved bits set");
   a_globb_reserved:
      assert property (reg_rd && reg_addr == 8'h72 |=> reg_rdata[7:1] == 7'h00)
      else $error("global fault b reserved bits set");
   a_warn_reserved:
      assert property (reg_rd && reg_addr == 8'h73 |=> (reg_rdata & 8'hFB) == 8'h00)
      else $error("warning reserved bits set");
   a_clk_status:
      assert property (s_clk_seen |=> reg_rdata[2])
      else $error("clock fault not shown in status");
   a_tick_mode:
      assert property (!ramp_manual_mode [*3] |-> !ramp_tick)
      else $error("ramp tick outside manual mode");
   a_read_answer:
      assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   a_report_pair:
      assert property (fault_report_n == !fault_report)
      else $error("report outputs not inverse");
endmodule
`default_nettype wire

//--- bench/afr_regs_tb.sv
// afr_regs_tb.sv: self-checking bench for the fault and ramp register slice.
// assumes: afr_regs and afr_regs_asserts are compiled before this file.
`default_nettype none
module afr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // *******************
   // stimulus and design
   // *******************
   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        mode = 1'b1;
   logic [12:0] det = 13'h0000;
   wire  [7:0]  rdata, div;
   wire  [3:0]  fall, rise;
   wire  [1:0]  amp;
   wire  [4:0]  plim;
   wire         rvalid, tick, rep, rep_n;
   int          errors = 0;
   int          tests_run = 0;
   int          ticks = 0;

   afr_regs u_afr_regs (.mclk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata(rdata), .reg_rvalid(rvalid), .ramp_manual_mode(mode),
      .left_dc_fault(det[0]), .right_dc_fault(det[1]), .left_overcurrent_fault(det[2]),
      .right_overcurrent_fault(det[3]), .otp_crc_fail(det[4]), .coef_write_error(det[5]),
      .clock_fault(det[6]), .power_supply_over_flag(det[7]),
      .power_supply_under_flag(det[8]), .thermal_shutdown_flag(det[9]),
      .thermal_warning(det[10]), .core_supply_under(det[11]), .core_supply_over(det[12]),
      .ramp_divisor(div), .tri_fall_step(fall), .tri_rise_step(rise),
      .ramp_amplitude_sel(amp), .tri_period_limit(plim), .ramp_tick(tick),
      .fault_report(rep), .fault_report_n(rep_n));

   // 100 MHz clock
   initial
   begin
      forever #5 mclk = ~mclk;
   end

   // count ramp ticks
   always @(posedge mclk)
      if (tick === 1'b1)
         ticks++;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("errors %0d, checks %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask

   // read one offset, wait a bounded time for the answer, compare
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      int n;
      @(negedge mclk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      reg_rd = 1'b0;
      for (n = 0; n < 4 && rvalid !== 1'b1; n++)
         @(negedge mclk);
      if (n == 4)
      begin
         $display("mismatch at %0t: read not answered", $time);
         errors++;
         stop_test();
      end
      else
         chk(rdata, exp);
   endtask

   task automatic t_reset;
      logic [7:0] rv [8] = '{8'h50, 8'h11, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++)
         rd(8'h6D + 8'(i), rv[i]);
      chk(div, 8'h50);
      chk({fall, rise}, 8'h11);
      chk({1'b0, amp, plim}, 8'h24);
      chk({6'h00, rep, rep_n}, 8'h01);
   endtask

   // count ticks over 10000 cycles in one mode
   task automatic t_tick(input logic m, input int lo, input int hi);
      mode = m;
      repeat (20) @(negedge mclk);
      ticks = 0;
      repeat (10000) @(negedge mclk);
      chk(8'(ticks >= lo && ticks <= hi), 8'h01);
   endtask

   task automatic t_rw;
      wr(8'h6E, 8'hA5);
      wr(8'h6F, 8'h5B);
      wr(8'h74, 8'hC3);
      rd(8'h6E, 8'hA5);
      rd(8'h6F, 8'h5B);
      rd(8'h74, 8'hC3);
      chk({fall, rise}, 8'hA5);
      chk({1'b0, amp, plim}, 8'h5B);
      for (int i = 0; i < 6; i++)
         wr(8'h70 + 8'(i), 8'hFF);
      for (int i = 0; i < 6; i++)
         rd(8'h70 + 8'(i), i == 4 ? 8'hFF : 8'h00);
      rd(8'h6C, 8'h00);
   endtask

   task automatic t_flags;
      wr(8'h74, 8'h00);
      det = 13'h1FFF;
      repeat (4) @(negedge mclk);
      rd(8'h70, 8'h0F);
      rd(8'h71, 8'hC7);
      rd(8'h72, 8'h01);
      rd(8'h73, 8'h04);
      chk({7'h00, rep}, 8'h01);
   endtask

   // each mask bit against one source of its kind
   task automatic t_mask;
      int src [8] = '{2, 0, 7, 8, 6, 12, 11, 9};
      for (int i = 0; i < 8; i++)
      begin
         det = 13'h0001 << src[i];
         wr(8'h74, ~(8'h01 << i));
         repeat (4) @(negedge mclk);
         chk({7'h00, rep}, 8'h01);
         wr(8'h74, 8'h01 << i);
         repeat (4) @(negedge mclk);
         chk({7'h00, rep}, 8'h00);
      end
      rd(8'h72, 8'h01);
   endtask

   // reset in mid-run: every register, field output and report output returns to its reset value
   task automatic t_rerun;
      det = 13'h0000;
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      t_reset();
   endtask

   initial
   begin
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      t_reset();
      t_tick(1'b1, 76, 77);
      t_tick(1'b0, 0, 0);
      wr(8'h6D, 8'h10);
      rd(8'h6D, 8'h10);
      t_tick(1'b1, 383, 385);
      t_rw();
      t_flags();
      t_mask();
      t_rerun();
      stop_test();
   end
endmodule

bind afr_regs afr_regs_asserts u_afr_regs_asserts (.mclk, .sys_rst, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .ramp_manual_mode, .clock_fault,
   .ramp_divisor, .tri_fall_step, .tri_rise_step, .ramp_amplitude_sel, .tri_period_limit,
   .ramp_tick, .fault_report, .fault_report_n);
`default_nettype wire

//--- shared/afr_consts.vh
// afr_consts.vh: offsets, field positions, reset values and timing for the
// amplifier fault and ramp spread register slice.
// assumes: included by the register slice design file by its bare name; the synchroniser does not include it.
`ifndef AFR_CONSTS_VH
`define AFR_CONSTS_VH

// register offsets on the control port
`define AFR_OFF_RAMP_DIV     8'h6D
`define AFR_OFF_TRI_STEP     8'h6E
`define AFR_OFF_TRI_SHAPE    8'h6F
`define AFR_OFF_PER_CHANNEL_FAULT_FLAGS   8'h70
`define AFR_OFF_GLOB_FAULT_A 8'h71
`define AFR_OFF_GLOB_FAULT_B 8'h72
`define AFR_OFF_THERM_WARN   8'h73
`define AFR_OFF_FAULT_MASK   8'h74

// reset values
`define AFR_RST_RAMP_DIV     8'h50
`define AFR_RST_TRI_STEP     8'h11
`define AFR_RST_TRI_SHAPE    8'h24
`define AFR_RST_FAULT_MASK   8'h00
`define AFR_RST_ZERO         8'h00

// reset values of the field outputs toward the ramp generator
`define AFR_RST_FALL_STEP    4'h1
`define AFR_RST_RISE_STEP    4'h1
`define AFR_RST_AMP_SEL      2'h1
`define AFR_RST_PLIM         5'h04

// step register fields
`define AFR_FALL_MSB         7
`define AFR_FALL_LSB         4
`define AFR_RISE_MSB         3
`define AFR_RISE_LSB         0

// shape register fields
`define AFR_AMP_MSB          6
`define AFR_AMP_LSB          5
`define AFR_PLIM_MSB         4
`define AFR_PLIM_LSB         0

// channel fault bits
`define AFR_BIT_LEFT_DC      3
`define AFR_BIT_RIGHT_DC     2
`define AFR_BIT_LEFT_OC      1
`define AFR_BIT_RIGHT_OC     0

// global fault a bits
`define AFR_BIT_OTP_CRC      7
`define AFR_BIT_COEF_WR      6
`define AFR_BIT_CLK_FAULT    2
`define AFR_BIT_PS_OVER      1
`define AFR_BIT_PS_UNDER     0

// global fault b and warning bits
`define AFR_BIT_THERM_SD     0
`define AFR_BIT_THERM_WARN   2

// mask register bits
`define AFR_MSK_THERM_SD     7
`define AFR_MSK_CORE_UNDER   6
`define AFR_MSK_CORE_OVER    5
`define AFR_MSK_CLK          4
`define AFR_MSK_PS_UNDER     3
`define AFR_MSK_PS_OVER      2
`define AFR_MSK_DC           1
`define AFR_MSK_OC           0

// ramp reference in hertz and the mclk rate in hertz
`define AFR_REF_HZ           61440000
`define AFR_CLK_HZ           100000000

`endif

//--- verilog/afr_regs.v
// afr_regs.v: fault report and ramp spread register slice of the amplifier.
// assumes: the control port decoder gives a one cycle write or read strobe
// with an 8-bit offset; detector levels are asynchronous to mclk.
//
// Contract
// - ramp frequency is reference over divisor, reset 50
// - step bits 7-4 set fall step, reset 1
// - step bits 3-0 set rise step, reset 1
// - shape bits 6-5 select amplitude, reset 01
// - shape bits 4-0 set period limit, reset 4
// - channel faults: left dc bit3, right bit2
// - channel overcurrent: left bit1, right bit0
// - global a bit7 flags memory integrity failure
// - global a bit6 flags failed coefficient write
// - global a: clock bit2, over bit1, under bit0
// - global b bit0 flags thermal shutdown
// - warning bit2 flags die above 135 C
// - mask register layout, resets to zero
// - mask hides report, detection keeps running
// - manual fields act only in manual mode; only ramp_tick is gated, the field outputs follow their registers in any mode
`include "afr_consts.vh"
`default_nettype none

module afr_regs
(
   // clock and reset
   input  wire       mclk,
   input  wire       sys_rst,
   // control port
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_rvalid,
   // ramp controller mode from its own control bit
   input  wire       ramp_manual_mode,
   // detector levels, asynchronous
   input  wire       left_dc_fault,
   input  wire       right_dc_fault,
   input  wire       left_overcurrent_fault,
   input  wire       right_overcurrent_fault,
   input  wire       otp_crc_fail,
   input  wire       coef_write_error,
   input  wire       clock_fault,
   input  wire       power_supply_over_flag,
   input  wire       power_supply_under_flag,
   input  wire       thermal_shutdown_flag,
   input  wire       thermal_warning,
   input  wire       core_supply_under,
   input  wire       core_supply_over,
   // manual ramp settings toward the ramp generator
   output reg  [7:0] ramp_divisor,
   output reg  [3:0] tri_fall_step,
   output reg  [3:0] tri_rise_step,
   output reg  [1:0] ramp_amplitude_sel,
   output reg  [4:0] tri_period_limit,
   output reg        ramp_tick,
   // fault report summary after masking
   output reg        fault_report,
   output reg        fault_report_n
);

   // ************************************************************
   // input synchronisation
   // ************************************************************

   wire [12:0] det_raw;
   wire [12:0] det;

   assign det_raw = {core_supply_over, core_supply_under, thermal_warning,
                     thermal_shutdown_flag, power_supply_under_flag,
                     power_supply_over_flag, clock_fault, coef_write_error,
                     otp_crc_fail, right_overcurrent_fault,
                     left_overcurrent_fault, right_dc_fault, left_dc_fault};

   afr_sync #(.W(13)) u_sync
   (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (det_raw),
      .sync_out (det)
   );

   // ************************************************************
   // writable registers
   // ************************************************************

   reg [7:0] step_reg;
   reg [7:0] shape_reg;
   reg [7:0] fault_mask;

   // only the writable offsets accept data; the status offsets ignore it
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ramp_divisor <= `AFR_RST_RAMP_DIV;
         step_reg     <= `AFR_RST_TRI_STEP;
         shape_reg    <= `AFR_RST_TRI_SHAPE;
         fault_mask   <= `AFR_RST_FAULT_MASK;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `AFR_OFF_RAMP_DIV:
               ramp_divisor <= reg_wdata;
            `AFR_OFF_TRI_STEP:
               step_reg <= reg_wdata;
            `AFR_OFF_TRI_SHAPE:
               shape_reg <= reg_wdata;
            `AFR_OFF_FAULT_MASK:
               fault_mask <= reg_wdata;
            default:
               fault_mask <= fault_mask;
         endcase
      end
   end

   // ************************************************************
   // field outputs to the ramp generator
   // ************************************************************

   // field splits of the step and shape registers
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         tri_fall_step      <= `AFR_RST_FALL_STEP;
         tri_rise_step      <= `AFR_RST_RISE_STEP;
         ramp_amplitude_sel <= `AFR_RST_AMP_SEL;
         tri_period_limit   <= `AFR_RST_PLIM;
      end
      else
      begin
         tri_fall_step      <= step_reg[`AFR_FALL_MSB:`AFR_FALL_LSB];
         tri_rise_step      <= step_reg[`AFR_RISE_MSB:`AFR_RISE_LSB];
         ramp_amplitude_sel <= shape_reg[`AFR_AMP_MSB:`AFR_AMP_LSB];
         tri_period_limit   <= shape_reg[`AFR_PLIM_MSB:`AFR_PLIM_LSB];
      end
   end

   // ************************************************************
   // manual ramp tick: reference over divisor
   // ************************************************************

   // phase accumulator steps by the reference rate each mclk and wraps at
   // divisor * clock rate, giving on average ref / divisor ticks per second
   localparam [39:0] REF_STEP = 40'd`AFR_REF_HZ;
   localparam [39:0] CLK_RATE = 40'd`AFR_CLK_HZ;

   reg  [39:0] ramp_acc;
   wire [39:0] ramp_lim;
   wire [39:0] acc_sum;

   assign ramp_lim = {32'h0, ramp_divisor} * CLK_RATE;
   assign acc_sum  = ramp_acc + REF_STEP;

   // only runs in manual mode; a zero divisor halts the tick
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         ramp_acc  <= 40'h0;
         ramp_tick <= 1'b0;
      end
      else if (!ramp_manual_mode || ramp_divisor == 8'h00)
      begin
         ramp_acc  <= 40'h0;
         ramp_tick <= 1'b0;
      end
      else if (acc_sum >= ramp_lim)
      begin
         ramp_acc  <= acc_sum - ramp_lim;
         ramp_tick <= 1'b1;
      end
      else
      begin
         ramp_acc  <= acc_sum;
         ramp_tick <= 1'b0;
      end
   end

   // ************************************************************
   // status registers
   // ************************************************************

   wire [7:0] per_channel_fault_flags;
   wire [7:0] glob_fault_a;
   wire [7:0] glob_fault_b;
   wire [7:0] therm_warn;

   // channel faults, reserved bits zero
   assign per_channel_fault_flags = {4'h0, det[0], det[1], det[2], det[3]};

   // global fault a: memory, coefficient, clock, supply
   assign glob_fault_a = {det[4],
                          det[5],
                          3'h0, det[6], det[7], det[8]};

   // thermal shutdown alone in global b
   assign glob_fault_b = {7'h00, det[9]};

   // warning alone at bit 2
   assign therm_warn = {5'h00, det[10], 2'h0};

   // ************************************************************
   // read port
   // ************************************************************

   reg [7:0] next_rdata;

   // reserved bits read as their zero reset; unmapped offsets read zero
   always @*
   begin
      next_rdata = `AFR_RST_ZERO;
      case (reg_addr)
         `AFR_OFF_RAMP_DIV:     next_rdata = ramp_divisor;
         `AFR_OFF_TRI_STEP:     next_rdata = step_reg;
         `AFR_OFF_TRI_SHAPE:    next_rdata = shape_reg;
         `AFR_OFF_PER_CHANNEL_FAULT_FLAGS:   next_rdata = per_channel_fault_flags;
         `AFR_OFF_GLOB_FAULT_A: next_rdata = glob_fault_a;
         `AFR_OFF_GLOB_FAULT_B: next_rdata = glob_fault_b;
         `AFR_OFF_THERM_WARN:   next_rdata = therm_warn;
         `AFR_OFF_FAULT_MASK:   next_rdata = fault_mask;
         default:               next_rdata = `AFR_RST_ZERO;
      endcase
   end

   // read data registered, valid one cycle after the strobe
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         reg_rdata  <= `AFR_RST_ZERO;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= next_rdata;
      end
   end

   // ************************************************************
   // masked fault report
   // ************************************************************

   wire [7:0] fault_vec;
   wire       next_report;

   // vector ordered like the mask register
   assign fault_vec = {det[9],                        // thermal shutdown
                       det[11],                       // core supply under
                       det[12],                       // core supply over
                       det[6],                        // clock
                       det[8],                        // power supply under
                       det[7],                        // power supply over
                       det[0] | det[1],               // dc
                       det[2] | det[3]};              // overcurrent

   // masking touches only the report; status registers keep raw flags
   assign next_report = |(fault_vec & ~fault_mask);

   // report pin levels
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         fault_report   <= 1'b0;
         fault_report_n <= 1'b1;
      end
      else
      begin
         fault_report   <= next_report;
         fault_report_n <= ~next_report;
      end
   end

endmodule

`default_nettype wire

//--- verilog/afr_sync.v
// afr_sync.v: two flop synchroniser for a bus of asynchronous levels.
// assumes: one clock, synchronous active high reset.
`default_nettype none

module afr_sync
#(
   parameter W = 8
)
(
   // clock and reset
   input  wire         mclk,
   input  wire         sys_rst,
   // levels
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

   reg [W-1:0] meta;

   // first stage feeds only the second
   always @(posedge mclk)
   begin
      if (sys_rst)
      begin
         meta     <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

`default_nettype wire
